/* src/pm1_wake_defs.vh */
// Purpose: constants for the power-management wake and enable register group
// Assumes: byte-wide system I/O accesses, base from two configuration bytes
// Notes: offsets are relative to the configured base
`ifndef PM1_WAKE_DEFS_VH
`define PM1_WAKE_DEFS_VH
`define OFS_STATUS_HI 16'h0001
`define OFS_ENABLE_LO 16'h0002
`define OFS_ENABLE_HI 16'h0003
`define BIT_WAKE_FLAG 7
`define BIT_TIMER_CARRY_EN 0
`define BIT_GLOBAL_EVENT_EN 5
`define RST_STATUS_HI 8'h00
`define RST_ENABLE_LO 8'h00
`define RST_ENABLE_HI 8'h00
`define MASK_ENABLE_LO 8'h21
`define TIMER_MSB 23
`define ST_WORKING 1'b0
`define ST_SLEEPING 1'b1
`endif

/* src/pm_timer_carry.v */
// Purpose: detect each change of the power-management timer top bit
// Assumes: timer value synchronous to i_clk
// Notes: outputs a one-cycle pulse per change, either direction
`timescale 1ns/10ps
`include "pm1_wake_defs.vh"
module pm_timer_carry (
  // Clock and reset
  input wire i_clk,
  input wire i_sys_rst,
  // Timer
  input wire [23:0] i_timer,
  output reg o_carry
);
  reg msb_q;
  reg seen_q;
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      msb_q <= 1'b0;
      seen_q <= 1'b0;
      o_carry <= 1'b0;
    end else begin
      msb_q <= i_timer[`TIMER_MSB];
      seen_q <= 1'b1;
      // First sample after reset only primes the history
      o_carry <= seen_q && (msb_q != i_timer[`TIMER_MSB]);
    end
  end
endmodule // pm_timer_carry

/* src/pm1_wake_regs.v */
// Purpose: second status byte with wake flag and first/second enable bytes
// Assumes: single-cycle system I/O read/write strobes, synchronous inputs
// Notes: sleep/work state kept here; timer and first status byte logic kept outside
// Operation
// - Hardware sets wake flag bit 7 on any resume event while sleeping; no enable bit gates it.
// - Setting wake flag moves state machine from sleeping to working.
// - Writing one clears wake flag; writing zero leaves it alone.
// - Standby timer expiry also clears the wake flag.
// - Wake flag clear and all devices sleeping puts chip to sleep.
// - Status byte bits 0 to 6 are reserved, read zero.
// - Timer carry enable bit 0 lets timer carry flag raise interrupt.
// - Timer carry enable clear blocks interrupt even with flag set.
// - Enable byte bits 1 to 4 read back zero.
// - Global enable bit 5 with global flag raises active-low interrupt.
// - Timer carry flag set on every change of timer bit 23.
// - Firmware release write sets global flag; only write-one clears it.
// - Group base comes from two configuration bytes, fixed offsets.
`timescale 1ns/10ps
`include "pm1_wake_defs.vh"
module pm1_wake_regs (
  // Clock and reset
  input wire i_clk,
  input wire i_sys_rst,
  // System I/O access
  input wire [15:0] i_io_addr,
  input wire i_io_wr,
  input wire i_io_rd,
  input wire [7:0] i_io_wdata,
  output reg [7:0] o_io_rdata,
  output reg o_io_sel,
  // Base address configuration bytes
  input wire [7:0] i_base_address_high_cfg,
  input wire [7:0] i_base_address_low_cfg,
  // Power events
  input wire i_resume_event,
  input wire i_standby_expired,
  input wire i_all_devices_sleeping,
  input wire [23:0] i_pm_timer,
  // Firmware release and flag clears from the first status byte
  input wire i_firmware_release_set,
  input wire i_timer_carry_clear,
  input wire i_global_event_clear,
  // State and flags
  output reg o_sleeping,
  output reg o_timer_carry_flag,
  output reg o_global_event_flag,
  output reg o_firmware_release_bit,
  output reg o_sci_n
);
  reg wake_flag_q;
  reg [7:0] enable_lo_q;
  reg [7:0] enable_hi_q;
  wire carry;
  wire [15:0] base;
  wire [15:0] ofs;
  wire hit;
  wire wr_status_hi;
  wire wr_enable_lo;
  wire wr_enable_hi;
  wire wake_set;
  wire timer_d;
  wire global_d;
  wire [7:0] enable_lo_d;

  pm_timer_carry u_carry (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_timer(i_pm_timer),
    .o_carry(carry)
  );

  assign base = {i_base_address_high_cfg, i_base_address_low_cfg};
  assign ofs = i_io_addr - base;
  assign hit = (i_io_addr >= base) && (ofs <= `OFS_ENABLE_HI) && (ofs >= `OFS_STATUS_HI);
  assign wr_status_hi = i_io_wr && hit && (ofs == `OFS_STATUS_HI);
  assign wr_enable_lo = i_io_wr && hit && (ofs == `OFS_ENABLE_LO);
  assign wr_enable_hi = i_io_wr && hit && (ofs == `OFS_ENABLE_HI);
  assign wake_set = i_resume_event && o_sleeping;

  // Set wins over clear so an event in the clearing cycle survives
  assign timer_d = carry | (o_timer_carry_flag & ~i_timer_carry_clear);
  assign global_d = i_firmware_release_set |
                    (o_global_event_flag & ~i_global_event_clear);
  assign enable_lo_d = wr_enable_lo ? (i_io_wdata & `MASK_ENABLE_LO) : enable_lo_q;

  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      wake_flag_q <= 1'b0;
      enable_lo_q <= `RST_ENABLE_LO;
      enable_hi_q <= `RST_ENABLE_HI;
      o_sleeping <= `ST_WORKING;
      o_timer_carry_flag <= 1'b0;
      o_global_event_flag <= 1'b0;
      o_firmware_release_bit <= 1'b0;
      o_sci_n <= 1'b1;
      o_io_rdata <= 8'h00;
      o_io_sel <= 1'b0;
    end else begin
      if (wake_set) begin
        wake_flag_q <= 1'b1;
      end else if ((wr_status_hi && i_io_wdata[`BIT_WAKE_FLAG]) || i_standby_expired) begin
        wake_flag_q <= 1'b0;
      end
      case (o_sleeping)
        `ST_SLEEPING: begin
          if (wake_set) begin
            o_sleeping <= `ST_WORKING;
          end
        end
        `ST_WORKING: begin
          // Wake flag must be clear; a pending wake keeps the chip awake
          if (!wake_flag_q && !wake_set && i_all_devices_sleeping) begin
            o_sleeping <= `ST_SLEEPING;
          end
        end
        default: o_sleeping <= `ST_WORKING;
      endcase
      enable_lo_q <= enable_lo_d;
      if (wr_enable_hi) begin
        enable_hi_q <= i_io_wdata;
      end
      o_timer_carry_flag <= timer_d;
      o_global_event_flag <= global_d;
      if (i_firmware_release_set) begin
        o_firmware_release_bit <= 1'b1;
      end else if (i_global_event_clear) begin
        o_firmware_release_bit <= 1'b0;
      end
      // Level output, held while any enabled pair stays set
      o_sci_n <= ~((enable_lo_d[`BIT_TIMER_CARRY_EN] & timer_d) |
                   (enable_lo_d[`BIT_GLOBAL_EVENT_EN] & global_d));
      o_io_sel <= hit && (i_io_rd || i_io_wr);
      if (i_io_rd && hit) begin
        case (ofs)
          `OFS_STATUS_HI: o_io_rdata <= {wake_flag_q, 7'h00};
          `OFS_ENABLE_LO: o_io_rdata <= enable_lo_q;
          `OFS_ENABLE_HI: o_io_rdata <= enable_hi_q;
          default: o_io_rdata <= 8'h00;
        endcase
      end else begin
        o_io_rdata <= 8'h00;
      end
    end
  end
endmodule // pm1_wake_regs

/* test/pm1_wake_checker_properties.sv */
// Purpose: port checks for the wake/enable group. Assumes: one clock. Notes: enable byte mirrored here
`timescale 1ns/10ps
module pm1_wake_checker (
  input wire i_clk, i_sys_rst, i_io_wr, i_io_rd, i_resume_event, i_firmware_release_set, i_global_event_clear,
  input wire o_io_sel, o_sleeping, o_timer_carry_flag, o_global_event_flag, o_firmware_release_bit, o_sci_n,
  input wire [15:0] i_io_addr,
  input wire [7:0] i_io_wdata, o_io_rdata, i_base_address_high_cfg, i_base_address_low_cfg,
  input wire [23:0] i_pm_timer
);
  wire [15:0] ofs = i_io_addr - {i_base_address_high_cfg, i_base_address_low_cfg};
  wire hit = (i_io_wr | i_io_rd) && ofs >= 16'h0001 && ofs <= 16'h0003;
  reg [7:0] en_q;
  // Only bits 0 and 5 are stored, so the mirror masks the same way
  always @(posedge i_clk or posedge i_sys_rst)
    if (i_sys_rst) en_q <= 8'h00;
    else if (i_io_wr && ofs == 16'h0002) en_q <= i_io_wdata & 8'h21;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  sel_on_hit_a: assert property (hit |=> o_io_sel) else $error("sel");
  status_rsvd_a: assert property (i_io_rd && ofs == 16'h0001 |=> o_io_rdata[6:0] == 7'h00) else $error("st");
  enable_rsvd_a: assert property (i_io_rd && ofs == 16'h0002 |=> o_io_rdata[4:1] == 4'h0) else $error("en");
  wake_to_work_a: assert property (o_sleeping && i_resume_event |=> !o_sleeping) else $error("wk");
  carry_flag_a: assert property ($changed(i_pm_timer[23]) |=> ##1 o_timer_carry_flag) else $error("tc");
  sci_level_a: assert property (o_sci_n == !(o_timer_carry_flag && en_q[0] || o_global_event_flag && en_q[5]))
    else $error("sci");
  global_set_a: assert property (i_firmware_release_set |=> o_global_event_flag && o_firmware_release_bit)
    else $error("gs");
  global_clr_a: assert property (i_global_event_clear && !i_firmware_release_set |=> !o_global_event_flag)
    else $error("gc");
endmodule // pm1_wake_checker

/* test/io_host_model.sv */
// Purpose: host I/O cycles. Assumes: byte access. Notes: idle bus shows inverted junk so stale decodes show
`timescale 1ns/10ps
module io_host_model (
  input wire i_clk,
  output reg [15:0] o_addr = 16'h0000,
  output reg o_wr = 1'b0,
  output reg o_rd = 1'b0,
  output reg [7:0] o_wdata = 8'h00
);
  task io(input w, input [15:0] a, input [7:0] d);
    @(posedge i_clk) {o_addr, o_wr, o_rd, o_wdata} <= {a, w, !w, d};
    @(posedge i_clk) {o_addr, o_wr, o_rd, o_wdata} <= {~a, 2'b00, ~d};
  endtask
endmodule // io_host_model

/* test/pm1_wake_regs_tb_top.sv */
// Purpose: bench for the wake/enable group. Assumes: 50 ns clock. Notes: reads checked from a queue
`timescale 1ns/10ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin err_total++; $display("CHECK FAILED %0t bad", $time); end end
module pm1_wake_regs_tb_top;
  logic i_clk = 1'b0, i_sys_rst = 1'b1, i_all_devices_sleeping = 1'b0;
  logic [4:0] ev = 5'h00;
  logic [23:0] i_pm_timer = 24'h00_0000;
  logic [15:0] base = 16'h0000, i_io_addr;
  logic [7:0] i_io_wdata, o_io_rdata, r, exp_q[$];
  logic i_io_wr, i_io_rd, o_io_sel, o_sleeping, o_timer_carry_flag, o_global_event_flag, o_firmware_release_bit, o_sci_n;
  wire [7:0] i_base_address_high_cfg = base[15:8], i_base_address_low_cfg = base[7:0];
  wire i_resume_event = ev[0], i_standby_expired = ev[1], i_firmware_release_set = ev[2];
  wire i_timer_carry_clear = ev[3], i_global_event_clear = ev[4];
  int err_total = 0, compares = 0;
  initial forever #25 i_clk = ~i_clk;
  io_host_model io_host_model_i (.i_clk, .o_addr(i_io_addr), .o_wr(i_io_wr), .o_rd(i_io_rd), .o_wdata(i_io_wdata));
  pm1_wake_regs pm1_wake_regs_i (.*);
  always @(negedge i_clk) if (o_io_sel === 1'b1) begin
    if (exp_q.size() == 0) `CHK(1'b1, 1'b0)
    else `CHK(o_io_rdata, exp_q.pop_front())
  end
  task acc(input w, input [2:0] o, input [7:0] d, input [7:0] e);
    if (o != 0 && o < 4) exp_q.push_back(w ? 8'h00 : e);
    io_host_model_i.io(w, base + o, d);
  endtask
  task pls(input [4:0] m, input int n);
    @(posedge i_clk) ev <= m;
    @(posedge i_clk) ev <= 5'h00;
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task end_sim;
    $display("compares %0d errors %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #100000 err_total++;
    end_sim;
  end
  initial begin
    r = $urandom(97);
    base = $urandom % 16'hfff0;
    repeat (3) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    acc(0, 1, 0, 0); acc(0, 2, 0, 0); acc(0, 3, 0, 0);
    r = $urandom;
    acc(1, 2, 8'hff, 0); acc(0, 2, 0, 8'h21); acc(1, 3, r, 0); acc(0, 3, 0, r); acc(1, 0, r, 0); acc(1, 4, r, 0);
    $display("register test end");
    @(posedge i_clk) i_pm_timer <= 24'h80_0000;
    pls(0, 1); `CHK({o_timer_carry_flag, o_sci_n}, 2'b10)
    pls(8, 1); `CHK({o_timer_carry_flag, o_sci_n}, 2'b01)
    acc(1, 2, 8'h20, 0);
    @(posedge i_clk) i_pm_timer <= 24'h00_0000;
    pls(0, 1); `CHK({o_timer_carry_flag, o_sci_n}, 2'b11)
    pls(4, 1); `CHK({o_global_event_flag, o_firmware_release_bit, o_sci_n}, 3'b110)
    pls(16, 1); `CHK({o_global_event_flag, o_firmware_release_bit, o_sci_n}, 3'b001)
    $display("event test end");
    @(posedge i_clk) i_all_devices_sleeping <= 1'b1;
    pls(0, 1); `CHK(o_sleeping, 1'b1)
    pls(1, 0); `CHK(o_sleeping, 1'b0)
    acc(1, 1, 8'h7f, 0); acc(0, 1, 0, 8'h80); acc(1, 1, 8'h80, 0); acc(0, 1, 0, 0);
    pls(0, 1); `CHK(o_sleeping, 1'b1)
    pls(1, 0); pls(2, 0); acc(0, 1, 0, 0);
    $display("wake test end");
    repeat (3) @(posedge i_clk);
    end_sim;
  end
endmodule // pm1_wake_regs_tb_top
bind pm1_wake_regs pm1_wake_checker pm1_wake_checker_i (.*);
